// ### hdl/cctc_pkg.sv
package cctc_pkg;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] OFS_CTRL2    = 8'h00;
    localparam logic [7:0] OFS_CTRL1    = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_CAP1_HI  = 8'h0C;
    localparam logic [7:0] OFS_CAP1_LO  = 8'h10;
    localparam logic [7:0] OFS_CMP1_HI  = 8'h14;
    localparam logic [7:0] OFS_CMP1_LO  = 8'h18;
    localparam logic [7:0] OFS_CNT_HI   = 8'h1C;
    localparam logic [7:0] OFS_CNT_LO   = 8'h20;
    localparam logic [7:0] OFS_ACNT_HI  = 8'h24;
    localparam logic [7:0] OFS_ACNT_LO  = 8'h28;
    localparam logic [7:0] OFS_CAP2_HI  = 8'h2C;
    localparam logic [7:0] OFS_CAP2_LO  = 8'h30;
    localparam logic [7:0] OFS_CMP2_HI  = 8'h34;
    localparam logic [7:0] OFS_CMP2_LO  = 8'h38;

    // ==========================================================
    // Field positions
    localparam int B1_CAP_IE   = 7;
    localparam int B1_CMP_IE   = 6;
    localparam int B1_OVF_IE   = 5;
    localparam int B1_FORCE2   = 4;
    localparam int B1_FORCE1   = 3;
    localparam int B1_LVL2     = 2;
    localparam int B1_EDGE1    = 1;
    localparam int B1_LVL1     = 0;
    localparam int B2_PIN1_EN  = 7;
    localparam int B2_PIN2_EN  = 6;
    localparam int B2_SINGLE   = 5;
    localparam int B2_PWM      = 4;
    localparam int B2_CLK_HI   = 3;
    localparam int B2_CLK_LO   = 2;
    localparam int B2_EDGE2    = 1;
    localparam int B2_EXT_EDGE = 0;
    localparam int BS_FREEZE   = 2;
    // Flag vector order matches status bits 7 down to 3
    localparam int F_CAP1      = 4;
    localparam int F_CMP1      = 3;
    localparam int F_ROLL      = 2;
    localparam int F_CAP2      = 1;
    localparam int F_CMP2      = 0;

    // ==========================================================
    // Codes, reset values, counts
    localparam logic [1:0]  CLK_DIV4    = 2'h0;
    localparam logic [1:0]  CLK_DIV2    = 2'h1;
    localparam logic [1:0]  CLK_DIV8    = 2'h2;
    localparam logic [2:0]  PRE_T4      = 3'h3;
    localparam logic [2:0]  PRE_T2      = 3'h1;
    localparam logic [2:0]  PRE_T8      = 3'h7;
    localparam logic [7:0]  CMP_HI_RST  = 8'h80;
    localparam logic [15:0] CNT_RST     = 16'hFFFC;
    localparam logic [15:0] CNT_TOP     = 16'hFFFF;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic first_capture_pin;
        logic second_capture_pin;
        logic external_count_clock_pin;
    } cctc_pins_in_t;

    typedef struct packed {
        logic first_compare_pin;
        logic second_compare_pin;
        logic first_pin_routed;
        logic second_pin_routed;
        logic timer_irq;
    } cctc_pins_out_t;

    typedef struct packed {
        logic [7:0]     ctrl1;
        logic [7:0]     ctrl2;
        logic           freeze;
        logic [4:0]     flags;
        logic [4:0]     armed;
        logic [15:0]    cnt;
        logic [15:0]    cap1;
        logic [15:0]    cap2;
        logic [15:0]    cmp1;
        logic [15:0]    cmp2;
        logic           inh1;
        logic           inh2;
        logic [2:0]     presc;
        logic [2:0]     s_c1;
        logic [2:0]     s_c2;
        logic [2:0]     s_ex;
        logic           lvl1;
        logic           lvl2;
        cctc_pins_out_t pins;
        logic           awready;
        logic           wready;
        logic           arready;
        logic           bvalid;
        logic           rvalid;
        logic           aw_held;
        logic           w_held;
        logic [7:0]     awaddr;
        logic [7:0]     wdata;
        logic           wstrb0;
        logic [1:0]     bresp;
        logic [1:0]     rresp;
        logic [7:0]     rdata;
    } cctc_state_t;

endpackage

// ### hdl/cctc_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Capture irq enable routes either capture flag to the timer interrupt.
// - Compare irq enable routes either match flag to the timer interrupt.
// - Overflow irq enable routes the rollover flag to the timer interrupt.
// - Force-second bit copies second level to second pin output, outside the pulse modes.
// - Force-first bit copies first level to first pin output, outside the pulse modes.
// - Second level driven on second match; on first pin at PWM second match or at single-pulse capture-1 edge.
// - First capture edge bit: 0 falling, 1 rising edge captures.
// - First level driven on first pin at each first-value match.
// - First pin enable only routes output; compare logic always runs.
// - Second pin enable only routes output; compare logic always runs.
// - Single-pulse mode: capture-1 edge starts one pulse, length from first value.
// - PWM mode: pulse from first value, period from second value.
// - Clock select: 00 div4, 01 div2, 10 div8, 11 external clock.
// - Without an external clock pin, external selection stops the counter.
// - Second capture edge bit: 0 falling, 1 rising edge captures.
// - External clock edge bit: 0 falling, 1 rising edge counts.
// - Capture-1 flag on capture or PWM period end; status read then low byte.
// - First match flag on equality outside the pulse modes; cleared by status read then low byte.
// - Rollover flag on wrap to zero; alternate counter access never clears it.
// - Capture-2 flag on capture; cleared by status read then low byte.
// - Second match flag on equality outside PWM mode; cleared by status read then low byte.
// - Freeze bit stops prescaler, counter and compare pin outputs; registers stay usable.
// - PWM second-value match reloads counter to FFFC.
// - Compare high-byte write inhibits matching until low byte written.
module cctc_timer #(
    parameter bit EXT_CLK_PRESENT = 1'b1
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire cctc_pkg::cctc_pins_in_t pins_i,
    output cctc_pkg::cctc_pins_out_t     pins_o
);
    import cctc_pkg::*;

    cctc_state_t st;
    cctc_state_t n;
    logic        tick;
    logic        m1;
    logic        m2;
    logic        e1;
    logic        e2;
    logic        pwm;
    logic        single_pulse_select;
    logic        rd_go;
    logic        wr_go;
    logic        we;
    logic        cnt_sw_rst;
    logic        stat_rd;
    logic [7:0]  wa;
    logic [7:0]  wd;
    logic [15:0] cnt_inc;
    logic [4:0]  set;
    logic [4:0]  acc;
    logic [4:0]  clr;

    // ==========================================================
    // Helpers
    function automatic logic edge_hit(input logic [2:0] s, input logic rise);
        return (s[1] != s[2]) && (s[1] == rise);
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_CMP2_LO);
    endfunction

    function automatic logic touched(input logic rd, input logic [7:0] ra,
                                     input logic wr, input logic [7:0] wa2,
                                     input logic [7:0] off);
        return (rd && ra == off) || (wr && wa2 == off);
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        n = st;
        set = 5'h00;
        // Three-stage synchronisers; only stages two and three are compared
        n.s_c1 = {st.s_c1[1:0], pins_i.first_capture_pin};
        n.s_c2 = {st.s_c2[1:0], pins_i.second_capture_pin};
        n.s_ex = {st.s_ex[1:0], pins_i.external_count_clock_pin};
        e1 = edge_hit(st.s_c1, st.ctrl1[B1_EDGE1]);
        e2 = edge_hit(st.s_c2, st.ctrl2[B2_EDGE2]);
        pwm = st.ctrl2[B2_PWM];
        single_pulse_select = st.ctrl2[B2_SINGLE] && !pwm;

        // Write channels are accepted in either order
        if (s_axi_awvalid && st.awready) begin
            n.aw_held = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            n.w_held = 1'b1;
            n.wdata = s_axi_wdata[7:0];
            n.wstrb0 = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        wr_go = n.aw_held && n.w_held && !n.bvalid;
        wa = n.awaddr;
        wd = n.wdata;
        we = wr_go && n.wstrb0 && addr_ok(wa);
        if (wr_go) begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = addr_ok(wa) ? RESP_OKAY : RESP_SLVERR;
        end

        // Read channel
        if (st.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        rd_go = s_axi_arvalid && st.arready;
        stat_rd = rd_go && s_axi_araddr == OFS_STATUS;
        if (rd_go) begin
            n.rvalid = 1'b1;
            n.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                OFS_CTRL2:   n.rdata = st.ctrl2;
                OFS_CTRL1:   n.rdata = st.ctrl1;
                OFS_STATUS:  n.rdata = {st.flags, st.freeze, 2'h0};
                OFS_CAP1_HI: n.rdata = st.cap1[15:8];
                OFS_CAP1_LO: n.rdata = st.cap1[7:0];
                OFS_CMP1_HI: n.rdata = st.cmp1[15:8];
                OFS_CMP1_LO: n.rdata = st.cmp1[7:0];
                OFS_CNT_HI:  n.rdata = st.cnt[15:8];
                OFS_CNT_LO:  n.rdata = st.cnt[7:0];
                OFS_ACNT_HI: n.rdata = st.cnt[15:8];
                OFS_ACNT_LO: n.rdata = st.cnt[7:0];
                OFS_CAP2_HI: n.rdata = st.cap2[15:8];
                OFS_CAP2_LO: n.rdata = st.cap2[7:0];
                OFS_CMP2_HI: n.rdata = st.cmp2[15:8];
                OFS_CMP2_LO: n.rdata = st.cmp2[7:0];
                default:     n.rdata = 8'h00;
            endcase
        end

        // Register writes
        cnt_sw_rst = 1'b0;
        if (we) begin
            case (wa)
                OFS_CTRL1:  n.ctrl1 = wd;
                OFS_CTRL2:  n.ctrl2 = wd;
                OFS_STATUS: n.freeze = wd[BS_FREEZE];
                OFS_CMP1_HI: begin
                    n.cmp1[15:8] = wd;
                    n.inh1 = 1'b1;
                end
                OFS_CMP1_LO: begin
                    n.cmp1[7:0] = wd;
                    n.inh1 = 1'b0;
                end
                OFS_CMP2_HI: begin
                    n.cmp2[15:8] = wd;
                    n.inh2 = 1'b1;
                end
                OFS_CMP2_LO: begin
                    n.cmp2[7:0] = wd;
                    n.inh2 = 1'b0;
                end
                OFS_CNT_LO:  cnt_sw_rst = 1'b1;
                OFS_ACNT_LO: cnt_sw_rst = 1'b1;
                default: ;
            endcase
        end

        // Prescaler and external clock
        tick = 1'b0;
        if (!st.freeze) begin
            case (st.ctrl2[B2_CLK_HI:B2_CLK_LO])
                CLK_DIV4: begin
                    tick = st.presc >= PRE_T4;
                    n.presc = tick ? 3'h0 : st.presc + 3'h1;
                end
                CLK_DIV2: begin
                    tick = st.presc >= PRE_T2;
                    n.presc = tick ? 3'h0 : st.presc + 3'h1;
                end
                CLK_DIV8: begin
                    tick = st.presc >= PRE_T8;
                    n.presc = tick ? 3'h0 : st.presc + 3'h1;
                end
                default: begin
                    tick = EXT_CLK_PRESENT &&
                           edge_hit(st.s_ex, st.ctrl2[B2_EXT_EDGE]);
                end
            endcase
        end

        // Counter, compares and captures
        cnt_inc = st.cnt + 16'h0001;
        m1 = tick && !st.inh1 && cnt_inc == st.cmp1;
        m2 = tick && !st.inh2 && cnt_inc == st.cmp2;
        if (tick) begin
            if (pwm && m2) begin
                n.cnt = CNT_RST;
                set[F_CAP1] = 1'b1;
                n.cap1 = cnt_inc;
            end else begin
                n.cnt = cnt_inc;
                set[F_ROLL] = st.cnt == CNT_TOP;
            end
        end
        if (!pwm) begin
            set[F_CMP1] = m1 && !single_pulse_select;
            set[F_CMP2] = m2;
        end
        if (e1 && !pwm && !single_pulse_select) begin
            set[F_CAP1] = 1'b1;
            n.cap1 = st.cnt;
        end
        if (e2) begin
            set[F_CAP2] = 1'b1;
            n.cap2 = st.cnt;
        end

        // Output levels
        if (pwm) begin
            if (m1) begin
                n.lvl1 = st.ctrl1[B1_LVL1];
            end
            if (m2) begin
                n.lvl1 = st.ctrl1[B1_LVL2];
            end
        end else if (single_pulse_select) begin
            if (e1) begin
                n.cnt = CNT_RST;
                n.presc = 3'h0;
                n.lvl1 = st.ctrl1[B1_LVL2];
            end else if (m1) begin
                n.lvl1 = st.ctrl1[B1_LVL1];
            end
        end else begin
            if (m1 || st.ctrl1[B1_FORCE1]) begin
                n.lvl1 = st.ctrl1[B1_LVL1];
            end
            if (m2 || st.ctrl1[B1_FORCE2]) begin
                n.lvl2 = st.ctrl1[B1_LVL2];
            end
        end
        if (cnt_sw_rst) begin
            n.cnt = CNT_RST;
            n.presc = 3'h0;
        end

        // Flag clearing: status read arms, low-byte access clears; set wins
        acc[F_CAP1] = touched(rd_go, s_axi_araddr, wr_go, wa, OFS_CAP1_LO);
        acc[F_CMP1] = touched(rd_go, s_axi_araddr, wr_go, wa, OFS_CMP1_LO);
        acc[F_ROLL] = touched(rd_go, s_axi_araddr, wr_go, wa, OFS_CNT_LO);
        acc[F_CAP2] = touched(rd_go, s_axi_araddr, wr_go, wa, OFS_CAP2_LO);
        acc[F_CMP2] = touched(rd_go, s_axi_araddr, wr_go, wa, OFS_CMP2_LO);
        clr = st.armed & acc;
        n.flags = set | (st.flags & ~clr);
        n.armed = (stat_rd ? (st.armed | st.flags) : st.armed) & ~acc;

        // Pins and interrupt
        n.pins.first_pin_routed = n.ctrl2[B2_PIN1_EN] && !n.freeze;
        n.pins.second_pin_routed = n.ctrl2[B2_PIN2_EN] && !n.freeze;
        n.pins.first_compare_pin = n.pins.first_pin_routed && n.lvl1;
        n.pins.second_compare_pin = n.pins.second_pin_routed && n.lvl2 &&
                                    !n.ctrl2[B2_PWM] && !n.ctrl2[B2_SINGLE];
        n.pins.timer_irq =
            (n.ctrl1[B1_CAP_IE] && (n.flags[F_CAP1] || n.flags[F_CAP2])) ||
            (n.ctrl1[B1_CMP_IE] && (n.flags[F_CMP1] || n.flags[F_CMP2])) ||
            (n.ctrl1[B1_OVF_IE] && n.flags[F_ROLL]);

        n.awready = !n.aw_held && !n.bvalid;
        n.wready = !n.w_held && !n.bvalid;
        n.arready = !n.rvalid;
    end

    // ==========================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.cmp1[15:8] <= CMP_HI_RST;
            st.cmp2[15:8] <= CMP_HI_RST;
            st.cnt <= CNT_RST;
        end else begin
            st <= n;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rresp   = st.rresp;
    assign s_axi_rdata   = {24'h000000, st.rdata};
    assign pins_o        = st.pins;

    // ==========================================================
    // Checks
    a_capture_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
        st.ctrl1[B1_CAP_IE] && st.flags[F_CAP2] |-> pins_o.timer_irq)
        else $error("capture flag enabled but no interrupt");
    a_irq_all_masked: assert property (@(posedge aclk) disable iff (!aresetn)
        st.ctrl1[7:5] == 3'h0 |-> !pins_o.timer_irq)
        else $error("interrupt raised while every enable is clear");
    a_rollover_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && st.cnt == CNT_TOP && !pwm |=> st.flags[F_ROLL] && st.cnt == 16'h0000)
        else $error("wrap to zero did not set rollover flag");
    a_freeze_holds_count: assert property (@(posedge aclk) disable iff (!aresetn)
        st.freeze && !cnt_sw_rst && !(single_pulse_select && e1) |=> $stable(st.cnt))
        else $error("counter moved while frozen");
    a_freeze_pins_low: assert property (@(posedge aclk) disable iff (!aresetn)
        st.freeze |-> !pins_o.first_compare_pin && !pins_o.second_compare_pin)
        else $error("compare pin driven while frozen");
    a_pwm_period_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        pwm && m2 && !cnt_sw_rst |=> st.cnt == CNT_RST && st.flags[F_CAP1])
        else $error("pwm period end did not reload counter");
    a_capture_edge_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        e1 && !pwm && !single_pulse_select |=> st.flags[F_CAP1] && st.cap1 == $past(st.cnt))
        else $error("selected capture edge not recorded");
    a_inhibit_blocks_match: assert property (@(posedge aclk) disable iff (!aresetn)
        st.inh1 && !st.flags[F_CMP1] && !we |=> !st.flags[F_CMP1])
        else $error("first match flag set while inhibited");
    a_unarmed_no_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        st.flags[F_CMP1] && !st.armed[F_CMP1] |=> st.flags[F_CMP1])
        else $error("match flag cleared without status read");
    a_prescale_div8: assert property (@(posedge aclk) disable iff (!aresetn)
        st.ctrl2[3:2] == CLK_DIV8 && tick |=> !tick [*7])
        else $error("divide by eight ticked too soon");

    // Pulse modes
    a_pwm_no_match: assert property (@(posedge aclk) disable iff (!aresetn)
        pwm && !st.flags[F_CMP1]
        |=> !st.flags[F_CMP1])
        else $error("first match flag set in pwm mode");
    a_pulse_start: assert property (@(posedge aclk) disable iff (!aresetn)
        single_pulse_select && e1
        |=> st.cnt == CNT_RST && st.lvl1 == $past(st.ctrl1[B1_LVL2]))
        else $error("single pulse did not start");
    a_pulse_frees_pin2: assert property (@(posedge aclk) disable iff (!aresetn)
        st.ctrl2[B2_PWM] || st.ctrl2[B2_SINGLE]
        |-> !pins_o.second_compare_pin)
        else $error("second pin driven in a pulse mode");
    a_pwm_capture_value: assert property (@(posedge aclk) disable iff (!aresetn)
        pwm && m2
        |=> st.cap1 == $past(cnt_inc))
        else $error("pwm period end not latched into capture");

endmodule

// ### tb/cctc_pins_model.sv
`timescale 1ns/1ps
module cctc_pins_model (
    input  wire logic               aclk,
    output cctc_pkg::cctc_pins_in_t pins
);
    import cctc_pkg::*;
    initial pins = '0;
    // ==========================================
    // Capture pins: p 0 first, 1 second
    task automatic cap(input int p, input logic v);
        @(posedge aclk);
        if (p == 0) begin
            pins.first_capture_pin <= v;
        end else begin
            pins.second_capture_pin <= v;
        end
        repeat (8) @(posedge aclk);
    endtask
    // ==========================================
    // External clock: n rising edges, left high
    task automatic ext_burst(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            pins.external_count_clock_pin <= 1'b1;
            repeat (6) @(posedge aclk);
            if (i < n - 1) begin
                pins.external_count_clock_pin <= 1'b0;
            end
            repeat (6) @(posedge aclk);
        end
    endtask
    task automatic ext_idle();
        @(posedge aclk);
        pins.external_count_clock_pin <= 1'b0;
    endtask
endmodule

// ### tb/cctc_timer_test.sv
`timescale 1ns/1ps
module cctc_timer_test;
    import cctc_pkg::*;
    logic           aclk;
    logic           aresetn;
    logic [7:0]     awaddr, araddr;
    logic [31:0]    wdata, rdata, d;
    logic [3:0]     wstrb;
    logic           awvalid, wvalid, bready, arvalid, rready;
    logic           awready, wready, bvalid, arready, rvalid;
    logic [1:0]     bresp, rresp;
    cctc_pins_in_t  pins_i;
    cctc_pins_out_t pins_o;
    int             mismatches, n_checks, cycles, hi, h0;
    logic [1:0]     sel [3] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8};
    int             dv [3] = '{2, 4, 8};

    cctc_timer i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pins_i(pins_i), .pins_o(pins_o)
    );
    cctc_pins_model i_pins (.aclk(aclk), .pins(pins_i));

    // ==========================================
    // Clock and hang guard
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        hi <= hi + pins_o.first_compare_pin;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ==========================================
    // Compares and bus tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkb(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic chkr(input string n, input int lo, input int hi, input logic [7:0] g);
        n_checks++;
        if ($isunknown(g) || g < lo || g > hi) begin
            mismatches++;
            $display("mismatch %s expected %0d..%0d seen %h", n, lo, hi, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(RESP_OKAY), 32'(bresp));
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        chk("rresp", 32'(er), 32'(rresp));
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
        rd(a, RESP_OKAY);
        chk(n, e, d);
    endtask
    // Freeze and return the counter to FFFC
    task automatic park();
        wr(OFS_STATUS, 8'h04);
        wr(OFS_CNT_LO, 8'h00);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // Tests
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rc(OFS_CTRL1, 32'h0, "ctrl1 reset");
        rc(OFS_CTRL2, 32'h0, "ctrl2 reset");
        rc(OFS_CMP1_HI, 32'h80, "cmp1 hi reset");
        rd(8'h3C, RESP_SLVERR);
        chk("unmapped data", 32'h0, d);
        $display("test reset done");
        foreach (dv[i]) begin
            park();
            wr(OFS_CTRL2, {4'h0, sel[i], 2'h0});
            wr(OFS_STATUS, 8'h00);
            repeat (80) @(posedge aclk);
            wr(OFS_STATUS, 8'h04);
            rd(OFS_CNT_LO, RESP_OKAY);
            chkr("ticks", 83 / dv[i] - 2, 83 / dv[i] + 2, d[7:0] - 8'hFC);
        end
        repeat (20) @(posedge aclk);
        rc(OFS_CNT_LO, d, "frozen count");
        rd(OFS_STATUS, RESP_OKAY);
        chkb("roll flag", 1'b1, d[5]);
        rd(OFS_ACNT_LO, RESP_OKAY);
        rd(OFS_STATUS, RESP_OKAY);
        chkb("roll kept", 1'b1, d[5]);
        rd(OFS_CNT_LO, RESP_OKAY);
        rd(OFS_STATUS, RESP_OKAY);
        chkb("roll cleared", 1'b0, d[5]);
        $display("test prescaler done");
        for (int e = 0; e < 2; e++) begin
            park();
            wr(OFS_CTRL2, {6'h03, 1'b0, e[0]});
            wr(OFS_STATUS, 8'h00);
            i_pins.ext_burst(5);
            wr(OFS_STATUS, 8'h04);
            i_pins.ext_idle();
            rd(OFS_CNT_LO, RESP_OKAY);
            chk("ext ticks", 32'(4 + e), {24'h0, d[7:0] - 8'hFC});
        end
        $display("test external clock done");
        park();
        for (int p = 0; p < 2; p++) begin
            for (int e = 0; e < 2; e++) begin
                wr(OFS_CTRL1, {6'h20, e[0], 1'b0});
                wr(OFS_CTRL2, {6'h00, e[0], 1'b0});
                i_pins.cap(p, 1'b1);
                rd(OFS_STATUS, RESP_OKAY);
                chkb("cap flag rise", e[0], d[p ? 4 : 7]);
                chkb("cap irq", e[0], pins_o.timer_irq);
                rd(p ? OFS_CAP2_LO : OFS_CAP1_LO, RESP_OKAY);
                i_pins.cap(p, 1'b0);
                rd(OFS_STATUS, RESP_OKAY);
                chkb("cap flag fall", !e[0], d[p ? 4 : 7]);
                rc(p ? OFS_CAP2_LO : OFS_CAP1_LO, 32'hFC, "cap lo");
            end
        end
        rc(OFS_CAP1_HI, 32'hFF, "cap1 hi");
        $display("test capture done");
        park();
        wr(OFS_CMP1_HI, 8'hFF);
        wr(OFS_CMP1_LO, 8'hFE);
        wr(OFS_CTRL1, 8'h41);
        wr(OFS_CTRL2, 8'h84);
        chkb("routed frozen", 1'b0, pins_o.first_pin_routed);
        chkb("irq idle", 1'b0, pins_o.timer_irq);
        wr(OFS_STATUS, 8'h00);
        repeat (20) @(posedge aclk);
        chkb("routed", 1'b1, pins_o.first_pin_routed);
        chkb("pin1 match", 1'b1, pins_o.first_compare_pin);
        chkb("cmp irq", 1'b1, pins_o.timer_irq);
        wr(OFS_STATUS, 8'h04);
        chkb("pin1 frozen", 1'b0, pins_o.first_compare_pin);
        wr(OFS_STATUS, 8'h00);
        wr(OFS_CTRL1, 8'h01);
        chkb("cmp irq masked", 1'b0, pins_o.timer_irq);
        rd(OFS_STATUS, RESP_OKAY);
        chkb("match flag", 1'b1, d[6]);
        rd(OFS_CMP1_LO, RESP_OKAY);
        rd(OFS_STATUS, RESP_OKAY);
        chkb("match cleared", 1'b0, d[6]);
        wr(OFS_CTRL1, 8'h08);
        @(posedge aclk);
        chkb("force low", 1'b0, pins_o.first_compare_pin);
        wr(OFS_CTRL1, 8'h09);
        @(posedge aclk);
        chkb("force high", 1'b1, pins_o.first_compare_pin);
        wr(OFS_CTRL1, 8'h20);
        chkb("roll irq", 1'b1, pins_o.timer_irq);
        $display("test compare done");
        park();
        wr(OFS_CMP2_HI, 8'h00);
        wr(OFS_CMP2_LO, 8'h04);
        wr(OFS_CTRL1, 8'h04);
        wr(OFS_CTRL2, 8'h94);
        wr(OFS_STATUS, 8'h00);
        repeat (20) @(posedge aclk);
        h0 = hi;
        repeat (32) @(posedge aclk);
        chk("pwm high cycles", 32'd8, hi - h0);
        wr(OFS_STATUS, 8'h04);
        rc(OFS_CAP1_LO, 32'h04, "pwm capture");
        rd(OFS_CNT_LO, RESP_OKAY);
        chkr("pwm reload", 0, 7, d[7:0] - 8'hFC);
        park();
        wr(OFS_CTRL1, 8'h06);
        wr(OFS_CTRL2, 8'hA4);
        wr(OFS_STATUS, 8'h00);
        repeat (10) @(posedge aclk);
        h0 = hi;
        i_pins.cap(0, 1'b1);
        chk("pulse length", 32'd4, hi - h0);
        $display("test pulse modes done");
        print_verdict();
    end
endmodule
